// ===== pkg/afp_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the fault manager
// Assumes: 100 MHz core clock
// Notes: Included by bare name; definitions only
`ifndef AFP_DEFINES_SVH
`define AFP_DEFINES_SVH

// Clock
`define AFP_CLK_PERIOD_NS 10

// Register byte offsets
`define AFP_REG_CTRL 8'h00
`define AFP_REG_STATUS 8'h04
`define AFP_REG_LIVE 8'h08

// Field positions
`define AFP_CTRL_SD_BIT 0
`define AFP_LIVE_ERR_LSB 0
`define AFP_LIVE_FAULT_BIT 8
`define AFP_LIVE_TOGGLE_BIT 9
`define AFP_LIVE_PLAY_BIT 10
`define AFP_ERR_WIDTH 6

// Reset values
`define AFP_CTRL_RESET 1'b1
`define AFP_STATUS_RESET 6'h00

// Timing: recovery timeout in microseconds, DC detect time in milliseconds
`define AFP_FAULT_RECOVERY_TIME_US 1000
`define AFP_FAULT_RECOVERY_CYCLES (`AFP_FAULT_RECOVERY_TIME_US * 1000 / `AFP_CLK_PERIOD_NS)
`define AFP_DC_DETECT_TIME_MS 420
`define AFP_DC_DETECT_CYCLES (`AFP_DC_DETECT_TIME_MS * 1000000 / `AFP_CLK_PERIOD_NS)

`endif

// ===== pkg/afp_pkg.sv
// Purpose: Types shared by the fault manager modules
// Assumes: Nothing beyond the defines header
// Notes: Bit 0 of an error vector is over-voltage
package afp_pkg;

  // One bit per protected error, over-voltage in bit 0
  typedef struct packed {
    logic over_temp_err;
    logic dc_detect_err;
    logic over_current_err;
    logic clock_err;
    logic under_voltage_err;
    logic over_voltage_err;
  } afp_err_t;

  // Output stage supervision states
  typedef enum logic [0:0] {
    AFP_RUN,
    AFP_LATCHED
  } afp_state_t;

  // Whole state of the manager
  typedef struct packed {
    afp_state_t st;
    logic toggle_seen;
    logic [31:0] timer;
    afp_err_t status;
    logic sd_bit;
    logic sd_prev;
    logic fault_drive;
    logic play_en;
    logic ack;
    logic [31:0] rdata;
  } afp_mgr_t;

endpackage

// ===== design/afp_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous levels
// Assumes: Each bit is a slow level, not a bus
// Notes: Bits are synchronised independently
`timescale 1ns/10ps
module afp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Levels
  input wire logic [WIDTH-1:0] din_i,
  output logic [WIDTH-1:0] dout_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } afp_sync_t;

  afp_sync_t sync_reg;
  afp_sync_t sync_next;

  ////////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always_comb
  begin
    sync_next.meta = din_i;
    sync_next.stable = sync_reg.meta;
  end

  // Reset to zero: a held-low shutdown reads as shutdown
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign dout_o = sync_reg.stable;

endmodule

// ===== design/afp_dc_detect.sv
// Purpose: DC detect timer per channel
// Assumes: Duty flags already synchronised; high while duty is beyond 60 percent
// Notes: A polarity change or a gap restarts the count
`timescale 1ns/10ps
`include "afp_defines.svh"
module afp_dc_detect #(
  parameter int CHANNELS = 2,
  parameter logic [31:0] DC_DETECT_CYCLES = `AFP_DC_DETECT_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Per channel duty flags
  input wire logic [CHANNELS-1:0] duty_pos_i,
  input wire logic [CHANNELS-1:0] duty_neg_i,
  // Result
  output logic dc_detect_err_o
);

  typedef struct packed {
    logic [CHANNELS-1:0][31:0] cnt;
    logic [CHANNELS-1:0] pol;
    logic err;
  } afp_dc_t;

  afp_dc_t dc_reg;
  afp_dc_t dc_next;
  logic [CHANNELS-1:0][31:0] cnt_n;
  logic [CHANNELS-1:0] hit_n;

  ////////////////////////////////////////////////////////////////////////////////
  // One counter per channel; saturates one above the limit
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_ch
      logic beyond;
      assign beyond = duty_pos_i[ch] ^ duty_neg_i[ch];
      // Fresh start on new excursion or polarity flip
      assign cnt_n[ch] = !beyond ? 32'h0 :
                         ((dc_reg.cnt[ch] == 32'h0) || (dc_reg.pol[ch] != duty_pos_i[ch])) ?
                         32'h1 :
                         (dc_reg.cnt[ch] > DC_DETECT_CYCLES) ? dc_reg.cnt[ch] :
                         dc_reg.cnt[ch] + 32'h1;
      assign hit_n[ch] = cnt_n[ch] > DC_DETECT_CYCLES; // Strictly longer
    end
  endgenerate

  // Gather per channel results
  always_comb
  begin
    dc_next.cnt = cnt_n;
    dc_next.pol = duty_pos_i;
    dc_next.err = |hit_n;
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dc_reg <= '0;
    end
    else
    begin
      dc_reg <= dc_next;
    end
  end

  assign dc_detect_err_o = dc_reg.err;

endmodule

// ===== design/afp_fault_mgr.sv
// Purpose: Fault supervision and recovery for a stereo class-D output stage
// Assumes: Detector levels arrive asynchronously; classic Wishbone register access
// Notes: Fault pin is open drain, driven low only through its enable
//   Hysteresis gates the exit from any latched fault, not only over-temperature
//   Status bits are sticky; a new event beats a write-one clear
//   The recovery timer runs from fault entry, not from the shutdown toggle
// How it works
// - Each error is latching or non-latching.
// - Latching errors clear only on shutdown toggle.
// - Error present at release re-enters fault.
// - Resume needs toggle, clean condition, elapsed timeout.
// - Non-latching errors recover automatically when gone.
// - Non-latching except clock never pull fault.
// - Clock error pulls fault, releases immediately.
// - Fault pin drives low or floats.
// - Latched fault holds line low until resume; here it floats once timed out and clean while shutdown is low or rising.
// - Every error has its own status bit.
// - Over-voltage is non-latching, no fault line.
// - Under-voltage is non-latching, no fault line.
// - Clock error from clock checker, clears valid.
// - Over-current latching; timeout plus toggle clear.
// - DC detect latching; timeout plus toggle clear.
// - Over-temp also needs fall below hysteresis.
// - DC error after 420 ms beyond 60%.
// - Shutdown low stops, high runs amplifier.
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "afp_defines.svh"
module afp_fault_mgr #(
  parameter int CHANNELS = 2,
  parameter logic [31:0] FAULT_RECOVERY_CYCLES = `AFP_FAULT_RECOVERY_CYCLES,
  parameter logic [31:0] DC_DETECT_CYCLES = `AFP_DC_DETECT_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Detector levels, asynchronous
  input wire logic over_voltage_i,
  input wire logic under_voltage_i,
  input wire logic clock_invalid_i,
  input wire logic over_current_i,
  input wire logic over_temp_i,
  input wire logic temp_above_hyst_i,
  input wire logic [CHANNELS-1:0] duty_pos_i,
  input wire logic [CHANNELS-1:0] duty_neg_i,
  // Shutdown pin, active low
  input wire logic amp_shutdown_n_i,
  // Open-drain fault pin
  output logic amp_fault_n_o,
  output logic amp_fault_n_oe_o,
  // Output stage control
  output logic play_en_o
);

  localparam int NSYNC = 7 + 2 * CHANNELS;

  afp_pkg::afp_mgr_t mgr_reg;
  afp_pkg::afp_mgr_t mgr_next;
  logic [NSYNC-1:0] sync_out;
  wire logic [NSYNC-1:0] sync_in;
  logic s_ov;
  logic s_uv;
  logic s_clk;
  logic s_oc;
  logic s_ot;
  logic s_hyst;
  logic s_sd_pin;
  logic [CHANNELS-1:0] s_pos;
  logic [CHANNELS-1:0] s_neg;
  logic dc_err;

  ////////////////////////////////////////////////////////////////////////////////
  // Gather every asynchronous level into one group, over-voltage in bit 0
  assign sync_in[0] = over_voltage_i;
  assign sync_in[1] = under_voltage_i;
  assign sync_in[2] = clock_invalid_i;
  assign sync_in[3] = over_current_i;
  assign sync_in[4] = over_temp_i;
  assign sync_in[5] = temp_above_hyst_i;
  assign sync_in[6] = amp_shutdown_n_i;
  assign sync_in[7 +: CHANNELS] = duty_pos_i;
  assign sync_in[7 + CHANNELS +: CHANNELS] = duty_neg_i;

  // Pin synchronisers; reset clears both stages, so the shutdown pin reads low
  // and the stage stays off until the pin has been seen high
  afp_sync #(
    .WIDTH(NSYNC)
  ) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .din_i(sync_in),
    .dout_o(sync_out)
  );

  // Split the synchronised group; bit order matches the gather above,
  // so a new detector must be added in both places
  assign s_ov = sync_out[0];
  assign s_uv = sync_out[1];
  assign s_clk = sync_out[2];
  assign s_oc = sync_out[3];
  assign s_ot = sync_out[4];
  assign s_hyst = sync_out[5];
  assign s_sd_pin = sync_out[6];
  assign s_pos = sync_out[7 +: CHANNELS];
  assign s_neg = sync_out[7 + CHANNELS +: CHANNELS];

  // DC detect timers; they see the synchronised duty flags, which adds two
  // cycles to a limit far longer than that, so the skew is not corrected
  // Limitation: only the count is checked, the duty threshold sits outside
  afp_dc_detect #(
    .CHANNELS(CHANNELS),
    .DC_DETECT_CYCLES(DC_DETECT_CYCLES)
  ) u_dc (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .duty_pos_i(s_pos),
    .duty_neg_i(s_neg),
    .dc_detect_err_o(dc_err)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    afp_pkg::afp_err_t live;
    afp_pkg::afp_err_t w1c;
    logic sd_n;
    logic sd_rise;
    logic latch_cond;
    logic latch_clean;
    logic access;
    logic reentry;
    logic release_ok;
    live = '0;
    w1c = '0;
    sd_n = 1'b0;
    sd_rise = 1'b0;
    latch_cond = 1'b0;
    latch_clean = 1'b0;
    access = 1'b0;
    reentry = 1'b0;
    release_ok = 1'b0;
    // Hold everything unless a branch below moves it
    mgr_next = mgr_reg;

    // Detector levels are read only after both flops, never straight from pins,
    // so a glitch shorter than a cycle may be missed; the detectors hold levels
    // Classify live conditions
    live.over_voltage_err = s_ov; // Non-latching
    live.under_voltage_err = s_uv; // Non-latching
    live.clock_err = s_clk; // Clock checker verdict
    live.over_current_err = s_oc;
    live.dc_detect_err = dc_err;
    live.over_temp_err = s_ot;
    latch_cond = s_oc | dc_err | s_ot; // Latching class
    // Over-temp must also be under hysteresis to count as gone
    latch_clean = !s_oc && !dc_err && !s_ot && !s_hyst;

    // Pin or control bit low means shutdown
    sd_n = s_sd_pin & mgr_reg.sd_bit;
    sd_rise = sd_n & !mgr_reg.sd_prev;
    mgr_next.sd_prev = sd_n;

    // Bus access: one-cycle ack, never back to back
    // A request still held after ack is taken again, so the master
    // must drop strobe on the edge at which it sees ack
    // Only byte lane 0 carries writable register bits
    access = wb_cyc_i & wb_stb_i & !mgr_reg.ack;
    mgr_next.ack = access;
    mgr_next.rdata = 32'h0;
    if (access && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == `AFP_REG_CTRL)
      begin
        mgr_next.sd_bit = wb_dat_i[`AFP_CTRL_SD_BIT];
      end
      if (wb_adr_i == `AFP_REG_STATUS)
      begin
        w1c = wb_dat_i[`AFP_ERR_WIDTH-1:0];
      end
    end

    // Latching supervision; the timer counts from entry, so a late toggle may
    // resume at once, while a toggle that still finds the cause present starts
    // the whole wait over
    unique case (mgr_reg.st)
      afp_pkg::AFP_RUN:
      begin
        if (latch_cond)
        begin
          mgr_next.st = afp_pkg::AFP_LATCHED;
          mgr_next.timer = FAULT_RECOVERY_CYCLES; // Timer starts at entry
          mgr_next.toggle_seen = 1'b0;
        end
      end
      afp_pkg::AFP_LATCHED:
      begin
        if (mgr_reg.timer != 32'h0)
        begin
          mgr_next.timer = mgr_reg.timer - 32'h1;
        end
        if (sd_rise && latch_cond)
        begin
          // Still faulty at release: fault again
          reentry = 1'b1;
          mgr_next.timer = FAULT_RECOVERY_CYCLES;
          mgr_next.toggle_seen = 1'b0;
        end
        else if (sd_rise)
        begin
          mgr_next.toggle_seen = 1'b1; // Only a toggle clears
        end
        else if (mgr_reg.toggle_seen && mgr_reg.timer == 32'h0 && sd_n && latch_clean)
        begin
          mgr_next.st = afp_pkg::AFP_RUN; // All four met, shutdown high included
          mgr_next.toggle_seen = 1'b0;
        end
      end
    endcase

    // Sticky status, a set beats a clear in the same cycle
    // so an event in the clearing cycle is never lost
    mgr_next.status = (mgr_reg.status & ~w1c) | live;
    if (reentry)
    begin
      mgr_next.status = mgr_next.status | (live & 6'h38);
    end

    // Once the timeout is over and the cause is gone, the line floats while shutdown
    // is low or just rising; a host that ties the line back to shutdown thus makes
    // its own toggle instead of waiting forever
    release_ok = (mgr_next.st == afp_pkg::AFP_LATCHED) && (mgr_next.timer == 32'h0) &&
                 latch_clean && (!sd_n || sd_rise);
    // Fault line: latched state or clock error only
    mgr_next.fault_drive = ((mgr_next.st == afp_pkg::AFP_LATCHED) && !release_ok) | s_clk;
    // Supply and clock errors mute without touching the latch state
    // Playback gated by live non-latching errors, no toggle needed
    mgr_next.play_en = (mgr_next.st == afp_pkg::AFP_RUN) & sd_n & !s_ov & !s_uv & !s_clk;

    // Read data is registered with ack and zero between answers,
    // so a stale word never sits on the bus
    // Read mux; unmapped reads return zero
    if (access && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `AFP_REG_CTRL:
        begin
          mgr_next.rdata = {31'h0, mgr_reg.sd_bit};
        end
        `AFP_REG_STATUS:
        begin
          mgr_next.rdata = {26'h0, mgr_reg.status};
        end
        `AFP_REG_LIVE:
        begin
          mgr_next.rdata = {21'h0, mgr_reg.play_en, mgr_reg.toggle_seen,
                            mgr_reg.st == afp_pkg::AFP_LATCHED, 2'h0, live};
        end
        default:
        begin
          mgr_next.rdata = 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  // Shutdown bit resets high, so software must clear it to stop the stage
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mgr_reg <= '0;
      mgr_reg.st <= afp_pkg::AFP_RUN;
      mgr_reg.sd_bit <= `AFP_CTRL_RESET;
      mgr_reg.status <= `AFP_STATUS_RESET;
    end
    else
    begin
      mgr_reg <= mgr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs; the pin level is always low, only the enable moves
  // The fault pin is never driven high; the pull-up owns the released level
  assign amp_fault_n_o = 1'b0;
  assign amp_fault_n_oe_o = mgr_reg.fault_drive;
  assign play_en_o = mgr_reg.play_en;
  assign wb_ack_o = mgr_reg.ack;
  assign wb_dat_o = mgr_reg.rdata;

endmodule

// ===== bench/afp_fault_mgr_asserts.sv
// Purpose: Concurrent checks on the fault manager ports
// Assumes: Detector levels held steady for several cycles by the bench
// Notes: Repetition counts allow for the two-flop input latency
`timescale 1ns/10ps
module afp_fault_mgr_asserts (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Detectors and pins
  input wire logic over_voltage_i,
  input wire logic under_voltage_i,
  input wire logic clock_invalid_i,
  input wire logic over_current_i,
  input wire logic amp_shutdown_n_i,
  input wire logic amp_fault_n_o,
  input wire logic amp_fault_n_oe_o,
  input wire logic play_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  // Pin data is never high, so the line is sunk or left to the pull-up
  fault_od_a: assert property (amp_fault_n_o == 1'b0)
    else $error("fault pin data not low");
  // A pulled line means the stage is held off
  fault_mute_a: assert property (amp_fault_n_oe_o |-> !play_en_o)
    else $error("playing while fault pulled");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_follow_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  clk_fault_a: assert property (clock_invalid_i [*5] |-> amp_fault_n_oe_o)
    else $error("clock error without fault line");
  oc_enter_a: assert property ($rose(over_current_i) |-> ##[3:5] amp_fault_n_oe_o)
    else $error("over-current not latched in time");
  oc_hold_a: assert property (over_current_i [*5] |-> amp_fault_n_oe_o)
    else $error("fault released with over-current present");
  supply_mute_a: assert property ((over_voltage_i || under_voltage_i) [*5] |-> !play_en_o)
    else $error("playing during supply error");
  sd_stop_a: assert property ((!amp_shutdown_n_i) [*5] |-> !play_en_o)
    else $error("playing in shutdown");
  // Main scenarios reached
  fault_on_c: cover property ($rose(amp_fault_n_oe_o));
  fault_off_c: cover property ($fell(amp_fault_n_oe_o));
  play_on_c: cover property ($rose(play_en_o));
endmodule
//////////////////////////////////////////////////////////////////////////////
bind afp_fault_mgr afp_fault_mgr_asserts u_afp_fault_mgr_asserts (.clock_i, .rst_n_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .over_voltage_i, .under_voltage_i, .clock_invalid_i,
  .over_current_i, .amp_shutdown_n_i, .amp_fault_n_o, .amp_fault_n_oe_o, .play_en_o);

// ===== bench/afp_host_model.sv
// Purpose: System host at the fault and shutdown pins
// Assumes: Pull-up on the fault net, shutdown driven push-pull
// Notes: Bench sets the shutdown level through sd_cmd_i
`timescale 1ns/10ps
module afp_host_model (
  // Open-drain fault pin from the block
  input wire logic amp_fault_n_o,
  input wire logic amp_fault_n_oe_o,
  // Shutdown request from the bench
  input wire logic sd_cmd_i,
  input wire logic tie_i,
  // Host side levels
  output logic fault_line_o,
  output logic amp_shutdown_n_o
);
  // Pull-up wins unless the block sinks the net
  assign fault_line_o = amp_fault_n_oe_o ? amp_fault_n_o : 1'b1;
  // Low stops the stage; a low then high pulse clears latches; with tie_i set the
  // fault net is also wired straight onto shutdown
  assign amp_shutdown_n_o = sd_cmd_i & (!tie_i | fault_line_o);
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the fault manager
// Assumes: Short recovery and DC counts set by parameter
// Notes: Pins are sampled just after an edge, before that edge lands
`timescale 1ns/10ps
module tb_top;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, oe, fault_n, fault_line, sd_pin, play_en_o, sd_cmd = 1'b1;
  logic ov = 1'b0, uv = 1'b0, ck = 1'b0, oc = 1'b0, ot = 1'b0, hyst = 1'b0;
  logic [1:0] duty = 2'h0, dneg = 2'h0;
  logic tie = 1'b0;
  int bad_count = 0, check_count = 0;
  //////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 clock_i = ~clock_i;
  afp_fault_mgr #(.FAULT_RECOVERY_CYCLES(32'h14), .DC_DETECT_CYCLES(32'ha)) u_afp_fault_mgr (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .over_voltage_i(ov), .under_voltage_i(uv),
    .clock_invalid_i(ck), .over_current_i(oc), .over_temp_i(ot), .temp_above_hyst_i(hyst),
    .duty_pos_i(duty), .duty_neg_i(dneg), .amp_shutdown_n_i(sd_pin),
    .amp_fault_n_o(fault_n), .amp_fault_n_oe_o(oe), .play_en_o(play_en_o));
  afp_host_model u_afp_host_model (.amp_fault_n_o(fault_n), .amp_fault_n_oe_o(oe),
    .sd_cmd_i(sd_cmd), .tie_i(tie), .fault_line_o(fault_line), .amp_shutdown_n_o(sd_pin));
  //////////////////////////////////////////////////////////////////////////////
  // Helpers; one Wishbone classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t pin got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic set_err(input int k, input logic v);
    case (k)
      0: ov <= v;
      1: uv <= v;
      2: ck <= v;
      3: oc <= v;
      4: duty[0] <= v;
      default: ot <= v;
    endcase
  endtask
  task automatic toggle_sd();
    sd_cmd <= 1'b0;
    wait_n(3);
    sd_cmd <= 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h0c, 32'hffff_ffff);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h400);
    wb(1'b1, 8'h00, 32'h0);
    wait_n(2);
    chk_pin(play_en_o, 1'b0);
    wb(1'b1, 8'h00, 32'h1);
    wait_n(2);
    chk_pin(play_en_o, 1'b1);
    $display("test regs done");
  endtask
  // Supply and clock errors recover alone; only the clock error pulls the line
  task automatic t_nonlatch();
    for (int k = 0; k < 3; k++)
    begin
      wb(1'b1, 8'h04, 32'h3f);
      set_err(k, 1'b1);
      wait_n(8);
      chk_pin(fault_line, k != 2);
      chk_pin(play_en_o, 1'b0);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h1 << k);
      set_err(k, 1'b0);
      wait_n(6);
      chk_pin(fault_line, 1'b1);
      chk_pin(play_en_o, 1'b1);
    end
    $display("test nonlatch done");
  endtask
  // Latching errors: need toggle, timeout and for heat the hysteresis
  task automatic t_latch(input int k);
    wb(1'b1, 8'h04, 32'h3f);
    hyst <= (k == 5);
    set_err(k, 1'b1);
    wait_n((k == 4) ? 18 : 5);
    set_err(k, 1'b0);
    toggle_sd();
    wait_n(2);
    chk_pin(fault_line, 1'b0);
    chk_pin(play_en_o, 1'b0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1 << k);
    wait_n(40);
    chk_pin(fault_line, k != 5);
    hyst <= 1'b0;
    wait_n(6);
    chk_pin(fault_line, 1'b1);
    chk_pin(play_en_o, 1'b1);
    $display("test latch %0d done", k);
  endtask
  // Toggle with error present, then clean without toggle, then control bit
  task automatic t_retoggle();
    set_err(3, 1'b1);
    wait_n(6);
    toggle_sd();
    wait_n(40);
    chk_pin(fault_line, 1'b0);
    set_err(3, 1'b0);
    wait_n(40);
    chk_pin(fault_line, 1'b0);
    wb(1'b1, 8'h00, 32'h0);
    wait_n(4);
    chk_pin(play_en_o, 1'b0);
    wb(1'b1, 8'h00, 32'h1);
    wait_n(8);
    chk_pin(fault_line, 1'b1);
    chk_pin(play_en_o, 1'b1);
    $display("test retoggle done");
  endtask
  // Ten cycles each way stays at the limit; a polarity flip restarts the count
  task automatic t_dcflip();
    wb(1'b1, 8'h04, 32'h3f);
    duty[0] <= 1'b1;
    wait_n(10);
    duty[0] <= 1'b0;
    dneg[0] <= 1'b1;
    wait_n(10);
    dneg[0] <= 1'b0;
    wait_n(8);
    chk_pin(fault_line, 1'b1);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    $display("test dcflip done");
  endtask
  // Fault net tied to shutdown: the block toggles itself once timed out with the cause gone
  task automatic t_tie();
    tie <= 1'b1;
    set_err(3, 1'b1);
    wait_n(6);
    set_err(3, 1'b0);
    wait_n(12);
    chk_pin(fault_line, 1'b0);
    chk_pin(play_en_o, 1'b0);
    wait_n(30);
    chk_pin(fault_line, 1'b1);
    chk_pin(play_en_o, 1'b1);
    tie <= 1'b0;
    $display("test tie done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    wait_n(16);
    rst_n_i <= 1'b1;
    wait_n(8);
    t_regs();
    t_nonlatch();
    for (int k = 3; k < 6; k++)
      t_latch(k);
    t_dcflip();
    t_retoggle();
    t_tie();
    results();
  end
  // Run needs about 500 cycles; a hang is cut at 30000
  initial
  begin
    #300000;
    bad_count++;
    results();
  end
endmodule
